// ### bench/field_model.sv
// Field wiring model: pulsed outputs looped back to inputs, with wiring faults
`timescale 1ns/100ps
`default_nettype none

module field_model (
    // Device side
    input  wire logic [7:0]  out_pin,
    input  wire logic [3:0]  lc_count,
    // Scenario control
    input  wire logic [19:0] free_level,
    input  wire logic [1:0]  fault_mode,
    input  wire logic [4:0]  fault_ch,
    // Wires into the inputs
    output logic [19:0]      level
);
    // ************************************************************
    // Wiring
    // ************************************************************
    always_comb
    begin
        level = free_level;
        for (int i = 0; i < 8; i++)
        begin
            if (i < int'(lc_count))
            begin
                level[i] = out_pin[i];
            end
        end
        case (fault_mode)
            2'h1: level[fault_ch] = 1'b0;
            2'h2: level[fault_ch] = 1'b1;
            2'h3:
            begin
                // Swapped pair, so no stale value survives on either wire
                level[0] = out_pin[1];
                level[1] = out_pin[0];
            end
            default: ;
        endcase
    end
endmodule
`default_nettype wire

// ### bench/test_safety_io_fault_supervisor.sv
// Self-checking bench of the safety I/O fault supervisor
`timescale 1ns/100ps
`default_nettype none

`define EXPECT(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
        end \
    end

module test_safety_io_fault_supervisor;
    // ************************************************************
    // Signals
    // ************************************************************
    logic                  REF_CLK = 1'b0;
    logic                  RST_N;
    sup_pkg::field_in_type fin;
    sup_pkg::user_in_type  uin;
    logic [7:0]            OUT_PIN;
    sup_pkg::user_out_type USER_OUT;
    sup_pkg::led_type      LED_OUT;
    logic [19:0]           lvl;
    logic [19:0]           model_level;
    logic [2:0][7:0]       sense;
    logic                  sup;
    logic [1:0]            fault_mode;
    logic [4:0]            fault_ch;
    int                    n_fail = 0;
    int                    compares = 0;

    always #10 REF_CLK = ~REF_CLK;

    always_comb
    begin
        fin = '{level: model_level, overload: sense[0], short_det: sense[1],
                signal_fault: sense[2], supply_ok: sup};
    end

    // Short counts keep the run brief; every expectation derives from them
    safety_io_fault_supervisor #(
        .FLASH_CYCLES   (20),
        .LC_STEP_CYCLES (16),
        .MS_CYCLES      (4)
    ) dut (
        .REF_CLK  (REF_CLK),
        .RST_N    (RST_N),
        .FIELD_IN (fin),
        .OUT_PIN  (OUT_PIN),
        .USER_IN  (uin),
        .USER_OUT (USER_OUT),
        .LED_OUT  (LED_OUT)
    );

    field_model field (
        .out_pin    (OUT_PIN),
        .lc_count   (uin.lc_count),
        .free_level (lvl),
        .fault_mode (fault_mode),
        .fault_ch   (fault_ch),
        .level      (model_level)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask

    task automatic finish_test();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_lamp();
        cyc(3);
        @(negedge REF_CLK);
        `EXPECT("leds in reset", 31'h0, LED_OUT)
        `EXPECT("user outputs in reset", 77'h0, USER_OUT)
        cyc(3);
        RST_N <= 1'b1;
        cyc(10);
        @(negedge REF_CLK);
        `EXPECT("lamp test", 31'h7FFFFFFF, LED_OUT)
        cyc(2100);
        @(negedge REF_CLK);
        `EXPECT("leds after lamp test", 31'h1, LED_OUT)
        $display("test lamp done");
    endtask

    task automatic t_inputs();
        cyc(1);
        lvl <= 20'hA5A5C;
        cyc(5);
        @(negedge REF_CLK);
        `EXPECT("input leds", 20'hA5A5C, LED_OUT.in_led)
        `EXPECT("input values", 20'hA5A5C, USER_OUT.in_value)
        cyc(1);
        lvl <= 20'h0;
        $display("test inputs done");
    endtask

    task automatic t_out_faults();
        int lit;
        cyc(1);
        uin.out_request <= 8'hFF;
        cyc(3);
        @(negedge REF_CLK);
        `EXPECT("output leds", 8'hFF, LED_OUT.out_led)
        for (int k = 0; k < 3; k++)
        begin
            cyc(1);
            sense[k][5] <= 1'b1;
            cyc(5);
            @(negedge REF_CLK);
            `EXPECT("faulty output off", 8'hDF, OUT_PIN)
            `EXPECT("output code", 2'(k + 1), USER_OUT.out_code[5])
            `EXPECT("io fault", 1'b1, USER_OUT.io_fault)
            lit = 0;
            repeat (80)
            begin
                @(negedge REF_CLK);
                lit += int'(LED_OUT.fault_led === 1'b1);
            end
            `EXPECT("fault led lit cycles", 40, lit)
            cyc(1);
            sense <= '0;
            cyc(5);
            @(negedge REF_CLK);
            `EXPECT("output back on", 8'hFF, OUT_PIN)
            `EXPECT("output code cleared", 2'h0, USER_OUT.out_code[5])
            `EXPECT("fault led dark", 1'b0, LED_OUT.fault_led)
        end
        $display("test output faults done");
    endtask

    task automatic t_device();
        cyc(1);
        uin.device_fault <= 1'b1;
        cyc(2);
        @(negedge REF_CLK);
        `EXPECT("all outputs off", 8'h00, OUT_PIN)
        `EXPECT("device codes", 16'hFFFF, USER_OUT.out_code)
        `EXPECT("device io fault", 1'b1, USER_OUT.io_fault)
        cyc(1);
        uin.device_fault <= 1'b0;
        uin.out_request <= 8'h00;
        $display("test device fault done");
    endtask

    task automatic t_comm_supply();
        for (int k = 0; k < 2; k++)
        begin
            cyc(1);
            uin.net_xfer <= 1'b1;
            cyc(1);
            uin.net_xfer <= 1'b0;
            cyc(2);
            @(negedge REF_CLK);
            `EXPECT("comm led", 1'(1 - k), LED_OUT.comm_led)
        end
        cyc(1);
        sup <= 1'b0;
        cyc(5);
        @(negedge REF_CLK);
        `EXPECT("supply led", 1'b0, LED_OUT.supply_led)
        cyc(1);
        sup <= 1'b1;
        $display("test comm and supply done");
    endtask

    task automatic lc_case(input logic [1:0] mode, input logic [4:0] ch);
        cyc(1);
        fault_mode <= mode;
        fault_ch <= ch;
        cyc(300);
        @(negedge REF_CLK);
    endtask

    task automatic t_line_control();
        int low0;
        int low1;
        int both;
        int odd;
        low0 = 0;
        low1 = 0;
        both = 0;
        odd = 0;
        cyc(1);
        uin.lc_count <= 4'h2;
        // Looped outputs still show the old request for one edge
        cyc(2);
        repeat (300)
        begin
            @(negedge REF_CLK);
            low0 += int'(OUT_PIN[0] === 1'b0);
            low1 += int'(OUT_PIN[1] === 1'b0);
            both += int'(OUT_PIN[1:0] === 2'b00);
            odd += int'(OUT_PIN[7:2] !== 6'h0);
        end
        `EXPECT("first output pulsed", 1'b1, low0 > 0)
        `EXPECT("second output pulsed", 1'b1, low1 > 0)
        `EXPECT("one pulse at a time", 0, both)
        `EXPECT("unlooped outputs quiet", 0, odd)
        `EXPECT("healthy codes", 4'h0, USER_OUT.in_code[1:0])
        `EXPECT("healthy values", 2'b11, USER_OUT.in_value[1:0])
        lc_case(2'h1, 5'd1);
        `EXPECT("open code", 2'h1, USER_OUT.in_code[1])
        `EXPECT("open value", 1'b0, USER_OUT.in_value[1])
        `EXPECT("open io fault", 1'b1, USER_OUT.io_fault)
        lc_case(2'h2, 5'd0);
        `EXPECT("cross code", 2'h2, USER_OUT.in_code[0])
        `EXPECT("cross value", 1'b0, USER_OUT.in_value[0])
        lc_case(2'h3, 5'd0);
        `EXPECT("miswire flagged", 1'b1, |USER_OUT.in_code[1:0])
        `EXPECT("miswire values", 2'b00, USER_OUT.in_value[1:0])
        lc_case(2'h0, 5'd0);
        `EXPECT("codes recovered", 4'h0, USER_OUT.in_code[1:0])
        `EXPECT("io fault gone", 1'b0, USER_OUT.io_fault)
        $display("test line control done");
    endtask

    // ************************************************************
    // Sequence and watchdog
    // ************************************************************
    initial
    begin
        RST_N = 1'b0;
        uin = '0;
        lvl = 20'h0;
        sense = '0;
        sup = 1'b1;
        fault_mode = 2'h0;
        fault_ch = 5'd0;
        t_lamp();
        t_inputs();
        t_out_faults();
        t_device();
        t_comm_supply();
        t_line_control();
        finish_test();
    end

    // Run needs under 5000 cycles, so this only trips on a hang
    initial
    begin
        cyc(20000);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire

// ### verilog/safety_io_fault_supervisor.sv
// Safety input/output fault supervision, line control and indicator drive
//
// Contract
// - Twenty inputs, each with its own indicator showing high or low.
// - An unmonitored open input line reads as safe low.
// - Faulty input shows low to the user with a per-channel error code.
// - Any input fault turns on the shared I/O fault indicator.
// - Line control pulses outputs 1..N contiguously, N at most eight.
// - Line-control fault forces input low, sets code, flashes fault indicator.
// - Eight outputs, each with its own indicator showing high or low.
// - Overloaded output switches off and returns by itself once cleared.
// - A detected output short is reported as a fault.
// - Faulty output signal de-energises that output and lights fault indicator.
// - Device fault switches all outputs off and lights fault indicator.
// - Slow flash: about 600 ms lit, 600 ms dark, repeating.
// - Communication indicator toggles with each network transfer.
// - At power-up all indicators light briefly together.
// - Supply indicator follows operating voltage only.
// - Fault indicator slow-flashes while any I/O fault exists, dark otherwise.
`timescale 1ns/100ps
`default_nettype none

module safety_io_fault_supervisor #(
    parameter int unsigned FLASH_CYCLES   = sup_pkg::SLOW_FLASH_CYCLES,
    parameter int unsigned LC_STEP_CYCLES = sup_pkg::LC_STEP_CYCLES,
    parameter int unsigned MS_CYCLES      = sup_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  RST_N,
    // Field side
    input  wire sup_pkg::field_in_type FIELD_IN,
    output logic [sup_pkg::N_OUT-1:0]  OUT_PIN,
    // User program side
    input  wire sup_pkg::user_in_type  USER_IN,
    output sup_pkg::user_out_type      USER_OUT,
    // Indicators
    output sup_pkg::led_type           LED_OUT
);

    typedef struct packed {
        sup_pkg::field_in_type                sync1;
        sup_pkg::field_in_type                sync2;
        sup_pkg::lc_state_type                lc_state;
        logic [3:0]                           lc_idx;
        logic [sup_pkg::N_OUT-1:0][1:0]       lc_pend;
        logic [sup_pkg::N_OUT-1:0][1:0]       lc_code;
        logic [sup_pkg::N_OUT-1:0]            lc_held;
        logic                                 flash_phase;
        logic                                 comm_state;
        logic                                 lamp_done;
        logic [9:0]                           lamp_cnt;
        logic [sup_pkg::N_OUT-1:0]            out_pin;
        sup_pkg::user_out_type                user;
        sup_pkg::led_type                     led;
    } sup_state_type;

    sup_state_type st;
    sup_state_type next_st;
    logic          flash_tick;
    logic          lc_tick;
    logic          ms_tick;

    // ************************************************************
    // Rate dividers
    // ************************************************************
    tick_divider #(.PERIOD(FLASH_CYCLES)) u_flash_div (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .tick  (flash_tick)
    );

    tick_divider #(.PERIOD(LC_STEP_CYCLES)) u_lc_div (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .tick  (lc_tick)
    );

    tick_divider #(.PERIOD(MS_CYCLES)) u_ms_div (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .tick  (ms_tick)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [3:0]                cnt;
        logic [sup_pkg::N_OUT-1:0] drive;
        logic [1:0]                code;
        logic                      lamp;
        cnt   = (USER_IN.lc_count > 4'h8) ? 4'h8 : USER_IN.lc_count;
        drive = '0;
        code  = sup_pkg::ERR_NONE;
        lamp  = !st.lamp_done;
        next_st = st;
        // Pins cross two flops before any logic reads them
        next_st.sync1 = FIELD_IN;
        next_st.sync2 = st.sync1;

        // Line-control sequencer: check high, pulse one output low, next
        unique case (st.lc_state)
            sup_pkg::LC_IDLE:
                if (lc_tick)
                begin
                    next_st.lc_idx  = 4'h0;
                    next_st.lc_pend = '0;
                    if (cnt != 4'h0)
                        next_st.lc_state = sup_pkg::LC_HIGH;
                    else
                        next_st.lc_code = '0;
                end
            sup_pkg::LC_HIGH:
                if (lc_tick)
                begin
                    for (int k = 0; k < sup_pkg::N_OUT; k++)
                    begin
                        if (k < int'(cnt))
                        begin
                            next_st.lc_held[k] = st.sync2.level[k];
                            if (!st.sync2.level[k] && st.lc_pend[k] == sup_pkg::ERR_NONE)
                                next_st.lc_pend[k] = sup_pkg::IN_ERR_OPEN;
                        end
                    end
                    if (st.lc_idx >= cnt)
                    begin
                        // Codes refresh every round, so they last as long as the fault
                        next_st.lc_code  = next_st.lc_pend;
                        next_st.lc_state = sup_pkg::LC_IDLE;
                    end
                    else
                    begin
                        next_st.lc_state = sup_pkg::LC_LOW;
                    end
                end
            sup_pkg::LC_LOW:
                if (lc_tick)
                begin
                    for (int k = 0; k < sup_pkg::N_OUT; k++)
                    begin
                        if (k < int'(cnt) && st.lc_pend[k] == sup_pkg::ERR_NONE)
                        begin
                            if (k == int'(st.lc_idx) && st.sync2.level[k])
                                next_st.lc_pend[k] = sup_pkg::IN_ERR_STUCK;
                            else if (k != int'(st.lc_idx) && st.lc_held[k]
                                     && !st.sync2.level[k])
                                next_st.lc_pend[k] = sup_pkg::IN_ERR_MISWIRE;
                        end
                    end
                    next_st.lc_idx   = st.lc_idx + 4'h1;
                    next_st.lc_state = sup_pkg::LC_HIGH;
                end
            default:
                next_st.lc_state = sup_pkg::LC_IDLE;
        endcase

        // Inputs: looped ones show the last high-phase sample, so test pulses stay hidden
        for (int k = 0; k < sup_pkg::N_IN; k++)
        begin
            if (k < sup_pkg::N_OUT && k < int'(cnt))
            begin
                code = st.lc_code[k];
                next_st.user.in_value[k] = (code == sup_pkg::ERR_NONE) && st.lc_held[k];
            end
            else
            begin
                code = sup_pkg::ERR_NONE;
                next_st.user.in_value[k] = st.sync2.level[k];
            end
            next_st.user.in_code[k] = code;
        end

        // Outputs: any fault de-energises; clearing the cause re-enables at once
        for (int i = 0; i < sup_pkg::N_OUT; i++)
        begin
            drive[i] = !(st.lc_state == sup_pkg::LC_LOW && int'(st.lc_idx) == i);
            if (USER_IN.device_fault || st.sync2.signal_fault[i])
                code = sup_pkg::OUT_ERR_SIGNAL;
            else if (st.sync2.short_det[i])
                code = sup_pkg::OUT_ERR_SHORT;
            else if (st.sync2.overload[i])
                code = sup_pkg::OUT_ERR_OVERLOAD;
            else
                code = sup_pkg::ERR_NONE;
            next_st.user.out_code[i] = code;
            next_st.out_pin[i] = (code == sup_pkg::ERR_NONE)
                && (i < int'(cnt) ? drive[i] : USER_IN.out_request[i]);
        end
        next_st.user.io_fault = (|next_st.user.in_code) || (|next_st.user.out_code)
            || USER_IN.device_fault;

        // Flash phase restarts lit whenever no fault is pending
        if (!st.user.io_fault)
            next_st.flash_phase = 1'b1;
        else if (flash_tick)
            next_st.flash_phase = !st.flash_phase;
        if (USER_IN.net_xfer)
            next_st.comm_state = !st.comm_state;
        if (!st.lamp_done && ms_tick)
        begin
            next_st.lamp_cnt = st.lamp_cnt + 10'h001;
            if (st.lamp_cnt == sup_pkg::LAMP_TEST_MS - 10'h001)
                next_st.lamp_done = 1'b1;
        end

        // Indicators, all forced lit during the power-up lamp test
        next_st.led.in_led     = lamp ? '1 : st.sync2.level;
        next_st.led.out_led    = lamp ? '1 : next_st.out_pin;
        next_st.led.fault_led  = lamp || (next_st.user.io_fault && st.flash_phase);
        next_st.led.comm_led   = lamp || st.comm_state;
        next_st.led.supply_led = lamp || st.sync2.supply_ok;
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            st <= '0;
        else
            st <= next_st;
    end

    assign OUT_PIN  = st.out_pin;
    assign USER_OUT = st.user;
    assign LED_OUT  = st.led;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [sup_pkg::N_IN-1:0]  in_bad;
    logic [sup_pkg::N_OUT-1:0] out_bad;

    always_comb
    begin
        for (int k = 0; k < sup_pkg::N_IN; k++)
            in_bad[k] = USER_OUT.in_code[k] != sup_pkg::ERR_NONE;
        for (int i = 0; i < sup_pkg::N_OUT; i++)
            out_bad[i] = USER_OUT.out_code[i] != sup_pkg::ERR_NONE;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    property p_in_led;
        st.lamp_done |=> LED_OUT.in_led == $past(st.sync2.level);
    endproperty
    a_in_led: assert property (p_in_led) else $error("input indicator wrong");

    property p_bad_in_low;
        (USER_OUT.in_value & in_bad) == '0;
    endproperty
    a_bad_in_low: assert property (p_bad_in_low) else $error("faulty input not low");

    property p_fault_led;
        $past(st.lamp_done) && LED_OUT.fault_led |-> USER_OUT.io_fault;
    endproperty
    a_fault_led: assert property (p_fault_led) else $error("fault indicator lit with no fault");

    property p_lc_pulse;
        st.lc_state == sup_pkg::LC_LOW |=> !OUT_PIN[$past(st.lc_idx[2:0])];
    endproperty
    a_lc_pulse: assert property (p_lc_pulse) else $error("tested output not pulsed low");

    property p_overload_off;
        |st.sync2.overload |=> (OUT_PIN & $past(st.sync2.overload)) == '0;
    endproperty
    a_overload_off: assert property (p_overload_off) else $error("overloaded output on");

    property p_short_code;
        |st.sync2.short_det |=> (out_bad & $past(st.sync2.short_det)) == $past(st.sync2.short_det);
    endproperty
    a_short_code: assert property (p_short_code) else $error("short not reported");

    property p_dev_off;
        USER_IN.device_fault |=> OUT_PIN == '0 && USER_OUT.io_fault;
    endproperty
    a_dev_off: assert property (p_dev_off) else $error("device fault left output on");

    property p_comm;
        USER_IN.net_xfer |=> st.comm_state != $past(st.comm_state);
    endproperty
    a_comm: assert property (p_comm) else $error("comm indicator did not toggle");

    property p_lamp;
        !st.lamp_done |=> &LED_OUT;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp test not all lit");

    property p_supply;
        st.lamp_done |=> LED_OUT.supply_led == $past(st.sync2.supply_ok);
    endproperty
    a_supply: assert property (p_supply) else $error("supply indicator wrong");

    property p_flash_hold;
        st.user.io_fault && !flash_tick |=> $stable(st.flash_phase);
    endproperty
    a_flash_hold: assert property (p_flash_hold) else $error("flash phase moved off tick");

    c_lc_fault: cover property (st.lc_state == sup_pkg::LC_HIGH ##1 |in_bad);
    c_overload: cover property (|st.sync2.overload ##1 |out_bad);
    c_lamp_end: cover property (!st.lamp_done ##1 st.lamp_done);

endmodule
`default_nettype wire

// ### verilog/sup_pkg.sv
// Shared constants and types of the safety I/O fault supervisor
package sup_pkg;

    // ************************************************************
    // Sizes and timing
    // ************************************************************
    localparam int unsigned N_IN              = 20;
    localparam int unsigned N_OUT             = 8;
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned CYCLES_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned CYCLES_PER_US     = CLK_HZ / 1_000_000;
    localparam int unsigned SLOW_FLASH_MS     = 600;
    localparam int unsigned SLOW_FLASH_CYCLES = SLOW_FLASH_MS * CYCLES_PER_MS;
    localparam int unsigned LC_STEP_US        = 200;
    localparam int unsigned LC_STEP_CYCLES    = LC_STEP_US * CYCLES_PER_US;
    localparam logic [9:0]  LAMP_TEST_MS      = 10'h1F4;

    // ************************************************************
    // Error codes
    // ************************************************************
    localparam logic [1:0] ERR_NONE         = 2'h0;
    localparam logic [1:0] IN_ERR_OPEN      = 2'h1;
    localparam logic [1:0] IN_ERR_STUCK     = 2'h2;
    localparam logic [1:0] IN_ERR_MISWIRE   = 2'h3;
    localparam logic [1:0] OUT_ERR_OVERLOAD = 2'h1;
    localparam logic [1:0] OUT_ERR_SHORT    = 2'h2;
    localparam logic [1:0] OUT_ERR_SIGNAL   = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        LC_IDLE = 2'h0,
        LC_HIGH = 2'h1,
        LC_LOW  = 2'h3
    } lc_state_type;

    typedef struct packed {
        logic [N_IN-1:0]  level;
        logic [N_OUT-1:0] overload;
        logic [N_OUT-1:0] short_det;
        logic [N_OUT-1:0] signal_fault;
        logic             supply_ok;
    } field_in_type;

    typedef struct packed {
        logic [N_OUT-1:0] out_request;
        logic [3:0]       lc_count;
        logic             device_fault;
        logic             net_xfer;
    } user_in_type;

    typedef struct packed {
        logic [N_IN-1:0]        in_value;
        logic [N_IN-1:0][1:0]   in_code;
        logic [N_OUT-1:0][1:0]  out_code;
        logic                   io_fault;
    } user_out_type;

    typedef struct packed {
        logic [N_IN-1:0]  in_led;
        logic [N_OUT-1:0] out_led;
        logic             fault_led;
        logic             comm_led;
        logic             supply_led;
    } led_type;

endpackage

// ### verilog/tick_divider.sv
// Free-running divider giving a one-cycle enable pulse every PERIOD cycles
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter int unsigned PERIOD = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Enable pulse
    output logic      tick
);

    localparam int unsigned W = $clog2(PERIOD + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } div_state_type;

    div_state_type st;
    div_state_type next_st;

    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.cnt == W'(PERIOD - 1))
        begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;

endmodule
`default_nettype wire
